// ===== channel_output_and_autotune.sv
// Channel outputs, dome press, maximum touch and automatic tuning
module channel_output_and_autotune #(
   parameter logic [23:0] sec_cycles_p = 24'(tpad_pkg::SEC_CYC)
) (
   input wire logic ref_clk_in,
   input wire logic srst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic wb_ack_out,
   output logic [31:0] wb_dat_out,
   input wire logic smp_in,
   input wire logic [2:0] ch_in,
   input wire logic [15:0] count_in,
   input wire logic comm_window_in,
   output logic [4:0] prox_out,
   output logic [3:0] touch_out,
   output logic [3:0] dome_out,
   output logic [7:0] max_touch_out,
   output logic [47:0] comp_out,
   output logic [35:0] gain_out,
   output logic reseed_out,
   output logic conv_stop_out,
   output logic i2c_hold_out
);
   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic [15:0][31:0] r;
      logic [4:0] prox;
      logic [3:0] touch;
      logic [3:0] dome;
      logic [4:0][7:0] dbp;
      logic [3:0][7:0] dbt;
      logic [3:0][7:0] dbd;
      logic [4:0][3:0] maxc;
      logic [4:0][3:0] minc;
      logic [16:0] bestd;
      logic [1:0] bestc;
      logic bestv;
      logic [7:0] maxt;
      logic [6:0][15:0] last;
      logic [31:0] lrep;
      logic [5:0][7:0] comp;
      logic [3:0][8:0] gain;
      tpad_pkg::tune_t fsm;
      logic grp;
      logic [7:0] tcnt;
      logic hold;
      logic [23:0] secc;
      logic [7:0] dsec;
      logic [7:0] hsec;
      logic reseed;
      logic stop;
   } st_t;

   st_t s_ff;
   st_t nxt_s;

   function automatic logic [31:0] bmask(input logic [3:0] sel);
      bmask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] sel);
      merge = (old & ~bmask(sel)) | (d & bmask(sel));
   endfunction

   // Unsigned global plus signed adjust, floored at zero
   function automatic logic [8:0] addc(input logic [7:0] g,
                                       input logic [7:0] a);
      logic [9:0] t;
      t = {2'b00, g} + {{2{a[7]}}, a};
      addc = t[9] ? 9'h000 : t[8:0];
   endfunction

   // Returns {output, new count}
   function automatic logic [8:0] deb(input logic q, input logic [7:0] c,
                                      input logic [7:0] lim);
      deb = {q && (c >= lim), q ? ((c == 8'hFF) ? c : c + 8'h01) : 8'h00};
   endfunction

   // Returns {trigger, new count} for a fifteen-sample streak
   function automatic logic [4:0] streak(input logic q, input logic [3:0] c);
      if (!q) begin
         streak = 5'h00;
      end else if (c == tpad_pkg::STREAK - 4'h1) begin
         streak = 5'h10;
      end else begin
         streak = {1'b0, c + 4'h1};
      end
   endfunction

   function automatic logic outside(input logic [15:0] v,
                                    input logic [15:0] goal,
                                    input logic [15:0] lim);
      outside = ({1'b0, v} > {1'b0, goal} + {1'b0, lim}) ||
                ({1'b0, v} + {1'b0, lim} < {1'b0, goal});
   endfunction

   logic [5:0] idx;
   logic over;
   logic [15:0] cval;
   logic [15:0] jref;
   logic [1:0] k;
   logic dm;
   logic [16:0] jdelta;
   logic jprox;
   logic jtouch;
   logic jdome;
   logic [31:0] rd;
   logic tick;
   logic tp_trig;
   logic lp_trig;
   logic err;
   logic ing;
   logic v;
   logic [8:0] dv;
   logic [4:0] sv;
   logic [2:0] ci;
   logic [2:0] li;
   logic [15:0] goal;
   logic [15:0] dlim;
   logic [1:0] col;
   logic [1:0] row;

   assign idx = wb_adr_in[7:2];
   assign k = ch_in[1:0];
   assign dm = s_ff.r[tpad_pkg::R_TMO][tpad_pkg::T_DMASK + int'(k)];
   assign over = count_in > s_ff.r[tpad_pkg::R_LIM][15:0];
   assign cval = (over || (ch_in < 3'h4 &&
                  !s_ff.r[tpad_pkg::R_TMO][tpad_pkg::T_ACT + int'(k)])) ?
                 16'h0000 : count_in;
   assign jref = (ch_in <= 3'h4) ?
                 s_ff.r[tpad_pkg::R_REF0 + {3'h0, ch_in}][15:0] : 16'h0000;

   channel_judge judge (
      .count_in(cval),
      .ref_in(jref),
      .prox_thr_in(s_ff.r[tpad_pkg::R_PROX][15:0]),
      .dome_thr_in(s_ff.r[tpad_pkg::R_TOUCH][31:16]),
      .lp_self_in((ch_in == 3'h4) &&
                  s_ff.r[tpad_pkg::R_CTRL][tpad_pkg::C_LPSELF]),
      .touch_now_in(s_ff.touch[k]),
      .mset_in(addc(s_ff.r[tpad_pkg::R_TOUCH][7:0],
                    s_ff.r[tpad_pkg::R_TADJ][8 * int'(k) +: 8])),
      .mclr_in(addc(s_ff.r[tpad_pkg::R_TOUCH][15:8],
                    s_ff.r[tpad_pkg::R_TADJ][8 * int'(k) +: 8])),
      .delta_out(jdelta),
      .prox_q_out(jprox),
      .touch_q_out(jtouch),
      .dome_q_out(jdome)
   );

   always_comb begin
      case (idx)
         tpad_pkg::R_STAT: begin
            rd = s_ff.r[tpad_pkg::R_STAT];
            rd[tpad_pkg::S_BUSY] = s_ff.fsm != tpad_pkg::T_IDLE;
         end
         tpad_pkg::R_OUT: begin
            rd = {8'h00, s_ff.maxt, 3'b000, s_ff.dome, s_ff.touch,
                  s_ff.prox};
         end
         tpad_pkg::R_LAST: rd = s_ff.lrep;
         tpad_pkg::R_COMP0: rd = s_ff.comp[3:0];
         tpad_pkg::R_COMP1: rd = {16'h0000, s_ff.comp[5:4]};
         default: begin
            rd = (idx < 6'(tpad_pkg::NREG)) ? s_ff.r[idx[3:0]] : 32'h0;
         end
      endcase
   end

   always_comb begin
      nxt_s = s_ff;
      nxt_s.reseed = 1'b0;
      nxt_s.stop = 1'b0;
      tick = 1'b0;
      tp_trig = 1'b0;
      lp_trig = 1'b0;
      err = 1'b0;
      ing = 1'b0;
      v = 1'b0;
      dv = 9'h000;
      sv = 5'h00;
      ci = 3'h0;
      li = 3'h0;
      col = 2'b00;
      row = 2'b00;
      goal = s_ff.grp ? s_ff.r[tpad_pkg::R_GOAL][31:16] :
                        s_ff.r[tpad_pkg::R_GOAL][15:0];
      dlim = s_ff.grp ? s_ff.r[tpad_pkg::R_DRIFT][31:16] :
                        s_ff.r[tpad_pkg::R_DRIFT][15:0];

      // Bus slave: answer one cycle after the request is seen
      nxt_s.ack = wb_cyc_in & wb_stb_in & ~s_ff.ack;
      if (nxt_s.ack) begin
         nxt_s.rdat = rd;
         if (wb_we_in && idx == tpad_pkg::R_STAT) begin
            nxt_s.r[tpad_pkg::R_STAT] = s_ff.r[tpad_pkg::R_STAT] &
               ~(wb_dat_in & bmask(wb_sel_in) & tpad_pkg::W1C_MASK);
         end else if (wb_we_in && idx < 6'(tpad_pkg::NREG)) begin
            nxt_s.r[idx[3:0]] = merge(s_ff.r[idx[3:0]], wb_dat_in,
                                      wb_sel_in);
         end
      end

      // Seconds timebase and retry hold-off
      if (s_ff.secc == sec_cycles_p - 24'h000001) begin
         nxt_s.secc = 24'h000000;
         tick = 1'b1;
      end else begin
         nxt_s.secc = s_ff.secc + 24'h000001;
      end
      if (tick && s_ff.hsec != 8'h00) begin
         nxt_s.hsec = s_ff.hsec - 8'h01;
      end

      for (int i = 0; i < tpad_pkg::NTP; i++) begin
         nxt_s.gain[i] = addc(s_ff.r[tpad_pkg::R_CLIM][23:16],
                              s_ff.r[tpad_pkg::R_GADJ][8 * i +: 8]);
      end

      if (smp_in && ch_in != 3'h7) begin
         nxt_s.stop = over;
         nxt_s.last[ch_in] = cval;
         nxt_s.lrep = {jdelta[15:0], cval};
         if (ch_in < 3'h4) begin
            dv = deb(jprox, s_ff.dbp[k], s_ff.r[tpad_pkg::R_PROX][23:16]);
            nxt_s.prox[k] = dv[8];
            nxt_s.dbp[k] = dv[7:0];
            dv = deb(jtouch, s_ff.dbt[k],
                     s_ff.r[tpad_pkg::R_PROX][31:24]);
            nxt_s.touch[k] = dv[8];
            nxt_s.dbt[k] = dv[7:0];
            dv = deb(jdome & dm, s_ff.dbd[k],
                     s_ff.r[tpad_pkg::R_PROX][31:24]);
            nxt_s.dome[k] = dv[8];
            nxt_s.dbd[k] = dv[7:0];
            // Strongest touch within this scan
            v = (k == 2'b00) ? 1'b0 : s_ff.bestv;
            if (nxt_s.touch[k] &&
                (!v || $signed(jdelta) > $signed(s_ff.bestd))) begin
               nxt_s.bestd = jdelta;
               nxt_s.bestc = k;
               v = 1'b1;
            end
            nxt_s.bestv = v;
            if (k == 2'b11) begin
               row = s_ff.r[tpad_pkg::R_CTRL][tpad_pkg::C_SWAP] ?
                     {1'b0, nxt_s.bestc[0]} : {1'b0, nxt_s.bestc[1]};
               col = s_ff.r[tpad_pkg::R_CTRL][tpad_pkg::C_SWAP] ?
                     {1'b0, nxt_s.bestc[1]} : {1'b0, nxt_s.bestc[0]};
               nxt_s.maxt = v ? {2'b00, col, 2'b00, row} : 8'hFF;
            end
         end else if (ch_in == 3'h4) begin
            dv = deb(jprox, s_ff.dbp[4], s_ff.r[tpad_pkg::R_PROX][23:16]);
            nxt_s.prox[4] = dv[8];
            nxt_s.dbp[4] = dv[7:0];
         end
         if (ch_in <= 3'h4) begin
            sv = streak(over, s_ff.maxc[ch_in]);
            nxt_s.maxc[ch_in] = sv[3:0];
            v = sv[4];
            sv = streak(!(ch_in < 3'h4 && dm) &&
                        ({1'b0, cval} + {1'b0, s_ff.r[tpad_pkg::R_LIM][31:16]}
                         < {1'b0, jref}), s_ff.minc[ch_in]);
            nxt_s.minc[ch_in] = sv[3:0];
            v = v | sv[4];
            if (ch_in == 3'h4) begin
               lp_trig = v | outside(jref, s_ff.r[tpad_pkg::R_GOAL][31:16],
                         s_ff.r[tpad_pkg::R_DRIFT][31:16]);
            end else begin
               tp_trig = v | outside(jref, s_ff.r[tpad_pkg::R_GOAL][15:0],
                         s_ff.r[tpad_pkg::R_DRIFT][15:0]);
            end
         end
         // Tuning step: a count above the goal lowers compensation
         ing = s_ff.grp ? (ch_in == 3'h5 || ch_in == 3'h6) :
                          (ch_in < 3'h4);
         ci = s_ff.grp ? ch_in - 3'h1 : ch_in;
         if (s_ff.fsm == tpad_pkg::T_RUN && ing &&
             s_ff.tcnt < tpad_pkg::TUNE_SAMPLES) begin
            if (cval > goal && s_ff.comp[ci] != 8'h00) begin
               nxt_s.comp[ci] = s_ff.comp[ci] - 8'h01;
            end else if (cval < goal && s_ff.comp[ci] != 8'hFF) begin
               nxt_s.comp[ci] = s_ff.comp[ci] + 8'h01;
            end
            nxt_s.tcnt = s_ff.tcnt + 8'h01;
         end
      end

      // Dome change flag and press timeout
      if (nxt_s.dome != s_ff.dome) begin
         nxt_s.r[tpad_pkg::R_STAT][tpad_pkg::S_DOME] = 1'b1;
         nxt_s.dsec = 8'h00;
      end else if (s_ff.dome == 4'h0) begin
         nxt_s.dsec = 8'h00;
      end else if (tick && s_ff.r[tpad_pkg::R_TMO][7:0] != 8'h00) begin
         // First tick after a change may come at once, so wait one more
         if (s_ff.dsec >= s_ff.r[tpad_pkg::R_TMO][7:0]) begin
            nxt_s.reseed = 1'b1;
            nxt_s.dsec = 8'h00;
         end else begin
            nxt_s.dsec = s_ff.dsec + 8'h01;
         end
      end

      case (s_ff.fsm)
         tpad_pkg::T_IDLE: begin
            if (s_ff.r[tpad_pkg::R_CTRL][tpad_pkg::C_REQ]) begin
               nxt_s.fsm = tpad_pkg::T_WAIT;
               nxt_s.grp = s_ff.r[tpad_pkg::R_CTRL][tpad_pkg::C_LPACT];
            end else if (s_ff.hsec == 8'h00 && tp_trig &&
                         s_ff.r[tpad_pkg::R_CTRL][tpad_pkg::C_RTEN] &&
                         !s_ff.r[tpad_pkg::R_CTRL][tpad_pkg::C_LPACT]) begin
               nxt_s.fsm = tpad_pkg::T_WAIT;
               nxt_s.grp = 1'b0;
               nxt_s.r[tpad_pkg::R_STAT][tpad_pkg::S_RT] = 1'b1;
            end else if (s_ff.hsec == 8'h00 && lp_trig &&
                         s_ff.r[tpad_pkg::R_CTRL][tpad_pkg::C_LPRTEN] &&
                         s_ff.r[tpad_pkg::R_CTRL][tpad_pkg::C_LPACT]) begin
               nxt_s.fsm = tpad_pkg::T_WAIT;
               nxt_s.grp = 1'b1;
               nxt_s.r[tpad_pkg::R_STAT][tpad_pkg::S_LPRT] = 1'b1;
            end
         end
         tpad_pkg::T_WAIT: begin
            if (!comm_window_in) begin
               nxt_s.fsm = tpad_pkg::T_RUN;
               nxt_s.hold = 1'b1;
               nxt_s.tcnt = 8'h00;
            end
         end
         tpad_pkg::T_RUN: begin
            if (s_ff.tcnt >= tpad_pkg::TUNE_SAMPLES) begin
               nxt_s.fsm = tpad_pkg::T_CHK;
            end
         end
         tpad_pkg::T_CHK: begin
            for (int i = 0; i < 6; i++) begin
               li = (i < 4) ? 3'(i) : 3'(i + 1);
               if ((s_ff.grp ? (i >= 4) : (i < 4)) &&
                   (s_ff.comp[i] <= s_ff.r[tpad_pkg::R_CLIM][7:0] ||
                    s_ff.comp[i] >= s_ff.r[tpad_pkg::R_CLIM][15:8] ||
                    outside(s_ff.last[li], goal, dlim))) begin
                  err = 1'b1;
               end
            end
            if (s_ff.grp) begin
               nxt_s.r[tpad_pkg::R_STAT][tpad_pkg::S_LPFLT] = err;
            end else begin
               nxt_s.r[tpad_pkg::R_STAT][tpad_pkg::S_FLT] = err;
            end
            if (err) begin
               nxt_s.hsec = s_ff.r[tpad_pkg::R_TMO][15:8];
            end
            nxt_s.r[tpad_pkg::R_CTRL][tpad_pkg::C_REQ] = 1'b0;
            nxt_s.hold = 1'b0;
            nxt_s.fsm = tpad_pkg::T_IDLE;
         end
         default: begin
            nxt_s.fsm = tpad_pkg::T_IDLE;
            nxt_s.hold = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         s_ff <= '0;
         s_ff.r[tpad_pkg::R_LIM] <= tpad_pkg::RST_LIM;
         s_ff.r[tpad_pkg::R_TMO] <= tpad_pkg::RST_TMO;
         s_ff.maxt <= 8'hFF;
         s_ff.fsm <= tpad_pkg::T_IDLE;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign wb_ack_out = s_ff.ack;
   assign wb_dat_out = s_ff.rdat;
   assign prox_out = s_ff.prox;
   assign touch_out = s_ff.touch;
   assign dome_out = s_ff.dome;
   assign max_touch_out = s_ff.maxt;
   assign comp_out = s_ff.comp;
   assign gain_out = s_ff.gain;
   assign reseed_out = s_ff.reseed;
   assign conv_stop_out = s_ff.stop;
   assign i2c_hold_out = s_ff.hold;
endmodule

// ===== tpad_pkg.sv
// Shared constants and types for the channel decision and tuning block
package tpad_pkg;
   localparam int NTP = 4;
   localparam int NREG = 16;
   // Register word indices; byte address is four times the index
   localparam logic [5:0] R_CTRL = 6'h00;
   localparam logic [5:0] R_STAT = 6'h01;
   localparam logic [5:0] R_PROX = 6'h02;
   localparam logic [5:0] R_TOUCH = 6'h03;
   localparam logic [5:0] R_GOAL = 6'h04;
   localparam logic [5:0] R_DRIFT = 6'h05;
   localparam logic [5:0] R_LIM = 6'h06;
   localparam logic [5:0] R_CLIM = 6'h07;
   localparam logic [5:0] R_TMO = 6'h08;
   localparam logic [5:0] R_TADJ = 6'h09;
   localparam logic [5:0] R_GADJ = 6'h0A;
   localparam logic [5:0] R_REF0 = 6'h0B;
   localparam logic [5:0] R_OUT = 6'h10;
   localparam logic [5:0] R_LAST = 6'h11;
   localparam logic [5:0] R_COMP0 = 6'h12;
   localparam logic [5:0] R_COMP1 = 6'h13;
   // Control bits
   localparam int C_REQ = 0;
   localparam int C_RTEN = 1;
   localparam int C_LPRTEN = 2;
   localparam int C_SWAP = 3;
   localparam int C_LPACT = 4;
   localparam int C_LPSELF = 5;
   // Status bits
   localparam int S_DOME = 0;
   localparam int S_RT = 1;
   localparam int S_LPRT = 2;
   localparam int S_FLT = 3;
   localparam int S_LPFLT = 4;
   localparam int S_BUSY = 5;
   localparam logic [31:0] W1C_MASK = 32'h0000_0007;
   // Timeout word fields
   localparam int T_DMASK = 16;
   localparam int T_ACT = 20;
   // Reset values
   localparam logic [31:0] RST_LIM = 32'h0000_FFFF;
   localparam logic [31:0] RST_TMO = 32'h00F0_0000;
   // Tuning and streak counts
   localparam logic [7:0] TUNE_SAMPLES = 8'h40;
   localparam logic [3:0] STREAK = 4'hF;
   // Seconds timebase
   localparam int CLK_HZ = 10_000_000;
   localparam int SEC_S = 1;
   localparam int SEC_CYC = SEC_S * CLK_HZ;
   typedef enum logic [3:0] {
      T_IDLE = 4'h1,
      T_WAIT = 4'h2,
      T_RUN = 4'h4,
      T_CHK = 4'h8
   } tune_t;
endpackage

// ===== channel_judge.sv
// Threshold comparisons for one channel sample
module channel_judge (
   input wire logic [15:0] count_in,
   input wire logic [15:0] ref_in,
   input wire logic [15:0] prox_thr_in,
   input wire logic [15:0] dome_thr_in,
   input wire logic lp_self_in,
   input wire logic touch_now_in,
   input wire logic [8:0] mset_in,
   input wire logic [8:0] mclr_in,
   output logic [16:0] delta_out,
   output logic prox_q_out,
   output logic touch_q_out,
   output logic dome_q_out
);
   function automatic logic [17:0] tthr(input logic [15:0] r,
                                        input logic [8:0] m);
      logic [24:0] p;
      p = 25'(r) * 25'(m);
      tthr = {2'b00, r} + p[24:7];
   endfunction

   logic [8:0] m;
   assign delta_out = {1'b0, count_in} - {1'b0, ref_in};
   // Self-capacitive low-power channel falls below its level
   assign prox_q_out = lp_self_in ?
      ({1'b0, count_in} + {1'b0, prox_thr_in} < {1'b0, ref_in}) :
      ({1'b0, count_in} > {1'b0, ref_in} + {1'b0, prox_thr_in});
   // Holding touch uses the release multiplier
   assign m = touch_now_in ? mclr_in : mset_in;
   assign touch_q_out = {2'b00, count_in} > tthr(ref_in, m);
   assign dome_q_out =
      {1'b0, count_in} + {1'b0, dome_thr_in} < {1'b0, ref_in};
endmodule

// ===== cot_checker_properties.sv
// Port-level timing checks for the channel output and tuning block
module cot_checker (
   input wire logic ref_clk_in,
   input wire logic srst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_ack_out,
   input wire logic [31:0] wb_dat_out,
   input wire logic smp_in,
   input wire logic [2:0] ch_in,
   input wire logic comm_window_in,
   input wire logic [4:0] prox_out,
   input wire logic [3:0] touch_out,
   input wire logic [3:0] dome_out,
   input wire logic [7:0] max_touch_out,
   input wire logic [47:0] comp_out,
   input wire logic reseed_out,
   input wire logic conv_stop_out,
   input wire logic i2c_hold_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);
   property p_ack;
      wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out;
   endproperty
   a_ack: assert property (p_ack) else $error("bus request not acked");
   property p_ack1;
      wb_ack_out |=> !wb_ack_out;
   endproperty
   a_ack1: assert property (p_ack1) else $error("ack longer than a cycle");
   property p_dat;
      $changed(wb_dat_out) |-> wb_ack_out;
   endproperty
   a_dat: assert property (p_dat) else $error("read data moved without ack");
   property p_rst;
      disable iff (1'b0) srst_in |=> max_touch_out == 8'hFF && !reseed_out;
   endproperty
   a_rst: assert property (p_rst) else $error("bad output in reset");
   property p_out;
      $changed({prox_out, touch_out, dome_out}) |-> $past(smp_in);
   endproperty
   a_out: assert property (p_out) else $error("flag moved without sample");
   property p_max;
      $changed(max_touch_out) |-> $past(smp_in && ch_in == 3'h3);
   endproperty
   a_max: assert property (p_max) else $error("max touch moved off scan end");
   property p_comp;
      $changed(comp_out) |-> $past(smp_in && i2c_hold_out);
   endproperty
   a_comp: assert property (p_comp) else $error("comp moved outside run");
   property p_hold;
      $rose(i2c_hold_out) |-> !$past(comm_window_in);
   endproperty
   a_hold: assert property (p_hold) else $error("run began in window");
   property p_rsd;
      reseed_out |-> $past(dome_out) != 4'h0 ##1 !reseed_out;
   endproperty
   a_rsd: assert property (p_rsd) else $error("reseed without press");
   property p_stop;
      conv_stop_out |-> $past(smp_in);
   endproperty
   a_stop: assert property (p_stop) else $error("stop without sample");
endmodule

bind channel_output_and_autotune cot_checker CHK (
   .ref_clk_in, .srst_in, .wb_cyc_in, .wb_stb_in, .wb_ack_out,
   .wb_dat_out, .smp_in, .ch_in, .comm_window_in, .prox_out, .touch_out,
   .dome_out, .max_touch_out, .comp_out, .reseed_out, .conv_stop_out,
   .i2c_hold_out
);

// ===== sensor_model.sv
// Electrode scan model: channels 0 to 6 in turn, one every other cycle
module sensor_model (
   input wire logic clk_in,
   input wire logic [6:0][15:0] val_in,
   output logic smp_out,
   output logic [2:0] ch_out,
   output logic [15:0] count_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] nx;
   assign nx = (ch_out == 3'h6) ? 3'h0 : ch_out + 3'h1;
   initial begin
      smp_out = 1'b0;
      ch_out = 3'h6;
      count_out = 16'h0000;
   end
   // Between samples the count line shows no stale value
   always @(posedge clk_in) begin
      smp_out <= ~smp_out;
      if (!smp_out) begin
         ch_out <= nx;
         count_out <= val_in[nx];
      end else begin
         count_out <= ~count_out;
      end
   end
endmodule

// ===== channel_output_and_autotune_test.sv
// Self-checking bench for the channel output and tuning block
module channel_output_and_autotune_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk_in = 1'b0, srst_in = 1'b1, wb_cyc_in = 1'b0;
   logic wb_stb_in = 1'b0, wb_we_in = 1'b0, comm_window_in = 1'b1;
   logic [7:0] wb_adr_in = 8'h00, max_touch_out;
   logic [3:0] wb_sel_in = 4'hF, touch_out, dome_out, ep, et;
   logic [31:0] wb_dat_in = 32'h0, wb_dat_out, q;
   logic wb_ack_out, smp_in, reseed_out, conv_stop_out, i2c_hold_out;
   logic [2:0] ch_in;
   logic [15:0] count_in, rs = 16'h0C94;
   logic [6:0][15:0] val;
   logic [4:0] prox_out;
   logic [47:0] comp_out;
   logic [35:0] gain_out;
   int error_cnt = 0, compares = 0, n, m;
   always #50 ref_clk_in = ~ref_clk_in;
   channel_output_and_autotune #(.sec_cycles_p(24'h000014)) DUT (
      .ref_clk_in, .srst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
      .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_ack_out, .wb_dat_out,
      .smp_in, .ch_in, .count_in, .comm_window_in, .prox_out,
      .touch_out, .dome_out, .max_touch_out, .comp_out, .gain_out,
      .reseed_out, .conv_stop_out, .i2c_hold_out
   );
   sensor_model PM (.clk_in(ref_clk_in), .val_in(val), .smp_out(smp_in),
      .ch_out(ch_in), .count_out(count_in));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic above(input logic [15:0] c, r,
                                  input logic [8:0] k);
      return 32'(c) * 32'h80 > 32'(r) * (32'h80 + 32'(k));
   endfunction
   task automatic close_out();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [47:0] g, e);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %0t: got %0h expected %0h", $time, g, e);
      end
   endtask
   task automatic wb(input logic w, input logic [5:0] i,
                     input logic [31:0] d);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= w;
      wb_adr_in <= {i, 2'b00};
      wb_dat_in <= d;
      do begin
         @(posedge ref_clk_in);
      end while (wb_ack_out !== 1'b1);
      q = wb_dat_out;
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
      @(posedge ref_clk_in);
   endtask
   task automatic wr(input logic [5:0] i, input logic [31:0] d);
      wb(1'b1, i, d);
   endtask
   task automatic rd(input logic [5:0] i, input logic [31:0] e, k);
      wb(1'b0, i, 32'h0);
      chk(48'(q & k), 48'(e));
   endtask
   task automatic idle();
      repeat (30) @(posedge ref_clk_in);
   endtask
   task automatic till(ref logic s, input logic v);
      n = 0;
      while (s !== v && n < 3000) begin
         @(posedge ref_clk_in);
         n++;
      end
      chk(48'(n < 3000), 48'h1);
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk_in);
      error_cnt++;
      close_out();
   end
   initial begin
      for (int k = 0; k < 7; k++) val[k] = 16'h03E8;
      repeat (10) @(posedge ref_clk_in);
      srst_in <= 1'b0;
      rd(tpad_pkg::R_LIM, tpad_pkg::RST_LIM, '1);
      rd(tpad_pkg::R_TMO, tpad_pkg::RST_TMO, '1);
      rd(tpad_pkg::R_CTRL, 32'h0, '1);
      chk(48'(max_touch_out), 48'hFF);
      wr(6'h3F, 32'hFFFFFFFF);
      rd(6'h3F, 32'h0, '1);
      for (int k = 0; k < 5; k++) wr(tpad_pkg::R_REF0 + 6'(k), 32'h03E8);
      wr(tpad_pkg::R_PROX, 32'h0000_0064);
      wr(tpad_pkg::R_TOUCH, 32'h00C8_1020);
      wr(tpad_pkg::R_TMO, 32'h00F4_2001);
      wr(tpad_pkg::R_CLIM, 32'h0040_FF00);
      wr(tpad_pkg::R_GADJ, 32'h0000_FF00);
      wr(tpad_pkg::R_LIM, 32'h0200_0600);
      chk(48'(gain_out), {12'h0, 9'h40, 9'h40, 9'h3F, 9'h40});
      val[1] <= 16'h0514;
      for (int r = 0; r < 4; r++) begin
         rs = lfsr(rs);
         val[0] <= 16'h0410 + {8'h0, rs[7:0]};
         val[3] <= 16'h03E8 + {10'h0, rs[13:8]};
         idle();
         for (int k = 0; k < 4; k++) begin
            ep[k] = val[k] > 16'h044C;
            et[k] = above(val[k], 16'h03E8, 9'h020);
         end
         chk(48'({prox_out, touch_out, max_touch_out}),
             48'({1'b0, ep, et, 8'h10}));
      end
      rd(tpad_pkg::R_STAT, 32'h0, 32'h1);
      val[2] <= 16'h02BC;
      while (dome_out !== 4'h4) @(posedge ref_clk_in);
      till(reseed_out, 1'b1);
      chk(48'(n >= 20 && n <= 40), 48'h1);
      chk(48'(dome_out), 48'h4);
      rd(tpad_pkg::R_STAT, 32'h1, 32'h1);
      val[2] <= 16'h0384;
      val[0] <= 16'h03E8;
      val[1] <= 16'h04B0;
      idle();
      chk(48'(touch_out[1]), 48'h1);
      val[1] <= 16'h0460;
      idle();
      chk(48'(touch_out[1]), 48'h0);
      val[1] <= 16'h0514;
      wr(tpad_pkg::R_CTRL, 32'h8);
      idle();
      chk(48'(max_touch_out), 48'h01);
      val[1] <= 16'h03E8;
      idle();
      chk(48'(max_touch_out), 48'hFF);
      wr(tpad_pkg::R_PROX, 32'h0002_0064);
      val[3] <= 16'h04B0;
      m = 0;
      n = 0;
      while (prox_out[3] !== 1'b1 && n < 200) begin
         @(posedge ref_clk_in);
         if (smp_in && ch_in == 3'h3 && count_in > 16'h044C) m++;
         n++;
      end
      chk(48'(m), 48'h3);
      for (int k = 0; k < 4; k++) val[k] <= 16'h0384;
      wr(tpad_pkg::R_GOAL, 32'h0000_03E8);
      wr(tpad_pkg::R_DRIFT, 32'h0000_00C8);
      wr(tpad_pkg::R_STAT, 32'h7);
      wr(tpad_pkg::R_CTRL, 32'h1);
      idle();
      chk(48'({i2c_hold_out, comp_out}), 48'h0);
      comm_window_in <= 1'b0;
      till(i2c_hold_out, 1'b1);
      till(i2c_hold_out, 1'b0);
      rd(tpad_pkg::R_CTRL, 32'h0, 32'h1);
      chk(comp_out, 48'h0000_1010_1010);
      rd(tpad_pkg::R_STAT, 32'h0, 32'h18);
      wr(tpad_pkg::R_CLIM, 32'h0040_FF20);
      wr(tpad_pkg::R_CTRL, 32'h1);
      till(i2c_hold_out, 1'b1);
      till(i2c_hold_out, 1'b0);
      rd(tpad_pkg::R_STAT, 32'h08, 32'h18);
      wr(tpad_pkg::R_CTRL, 32'h2);
      val[0] <= 16'h0640;
      till(conv_stop_out, 1'b1);
      till(i2c_hold_out, 1'b1);
      chk(48'(n >= 500), 48'h1);
      val[0] <= 16'h0384;
      till(i2c_hold_out, 1'b0);
      rd(tpad_pkg::R_STAT, 32'h2, 32'h6);
      wr(tpad_pkg::R_STAT, 32'h2);
      rd(tpad_pkg::R_STAT, 32'h0, 32'h2);
      val[5] <= 16'h0384;
      val[6] <= 16'h0384;
      wr(tpad_pkg::R_GOAL, 32'h03E8_03E8);
      wr(tpad_pkg::R_CTRL, 32'h11);
      till(i2c_hold_out, 1'b1);
      till(i2c_hold_out, 1'b0);
      chk(48'(comp_out[47:32]), 48'h2020);
      rd(tpad_pkg::R_STAT, 32'h10, 32'h10);
      close_out();
   end
endmodule
